/* design/reset_source_control.sv */
// reset source controller: brown-out dip filter, flash key reset, watchdog resets,
// timeout/powerdown flags and power-on defaults for core and peripherals
// assumes an apb master on pclk, a sub clock enable pulse, and a supply-ok pin
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////////////////
// Contract
// - width select picks 8/32/64/128 sub periods
// - width select bits 7..2 read zero
// - flash control one key 55H resets device
// - watchdog expiry while running sets timeout, resets
// - watchdog in sleep clears pc, sp only
// - power-on clears flags; sleep watchdog sets both
// - power-on disables all interrupts
// - power-on clears watchdog, time base; restarts
// - power-on switches timers off
// - power-on ports inputs, latches ones, enables zero
// - power-on pc zero, stack pointer top
// - only dips longer than width cause reset
module reset_source_control
  import rst_src_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sub_clk_en,
  input  wire logic              supply_ok,
  input  wire logic              wdt_expire,
  output logic                   sys_reset_n,
  output logic                   pc_sp_clear,
  output logic                   timeout_flag,
  output logic                   powerdown_flag,
  output logic                   int_enable,
  output logic                   wdt_tb_clear,
  output logic                   timer_enable,
  output logic      [PORT_W-1:0] port_dir,
  output logic      [PORT_W-1:0] port_data,
  output logic      [PORT_W-1:0] port_pull,
  output logic      [PORT_W-1:0] port_wake
);

  //////////////////////////////////////////////////////////////////////////////////////////
  // supply pin conditioning; low means supply below the brown-out threshold
  logic supply_ok_s;

  sync3 u_supply_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (supply_ok),
    .rst_val (1'b1),
    .dout    (supply_ok_s)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  // apb register state
  logic [1:0] width_sel_q, width_sel_d;
  logic       sleep_q, sleep_d;
  logic       to_q, to_d;
  logic       pd_q, pd_d;
  logic [31:0] rdata_q, rdata_d;
  logic       err_q, err_d;
  logic       rdy_q, rdy_d;
  logic       key_hit;
  logic       acc;

  // one wait state: pready rises the cycle after the access phase opens
  assign acc = psel & penable & ~rdy_q;

  // decode; unmapped addresses answer with pslverr
  always_comb begin
    width_sel_d = width_sel_q;
    sleep_d     = sleep_q;
    rdata_d     = 32'h0000_0000;
    err_d       = 1'b0;
    rdy_d       = acc;
    key_hit     = 1'b0;
    if (acc) begin
      case (paddr)
        ADDR_WIDTH_SEL: begin
          if (pwrite) width_sel_d = pwdata[1:0];
          rdata_d = {30'h0000_0000, width_sel_q}; // upper bits read zero
        end
        ADDR_FLASH_CTL1: begin
          if (pwrite && pwdata[7:0] == FLASH_KEY) key_hit = 1'b1;
        end
        ADDR_FLAGS: begin
          rdata_d = {30'h0000_0000, pd_q, to_q};
        end
        ADDR_CONTROL: begin
          if (pwrite) sleep_d = pwdata[CTL_SLEEP_BIT];
          rdata_d = {31'h0000_0000, sleep_q};
        end
        default: err_d = 1'b1;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // brown-out dip filter counted in sub clock periods
  logic [7:0] dip_cnt_q, dip_cnt_d;
  logic [7:0] dip_lim;
  logic       bor_fire;

  // limit per select code; reaching it means the dip outlasted the width
  always_comb begin
    case (width_sel_q)
      2'h0:    dip_lim = 8'(DIP_CYC_0);
      2'h1:    dip_lim = 8'(DIP_CYC_1);
      2'h2:    dip_lim = 8'(DIP_CYC_2);
      default: dip_lim = 8'(DIP_CYC_3);
    endcase
  end

  // any return of the supply restarts the count, so short dips never fire
  always_comb begin
    dip_cnt_d = dip_cnt_q;
    bor_fire  = 1'b0;
    if (supply_ok_s) begin
      dip_cnt_d = 8'h00;
    end else if (sub_clk_en) begin
      if (dip_cnt_q + 8'h01 >= dip_lim) begin
        bor_fire  = 1'b1;
        dip_cnt_d = 8'h00;
      end else begin
        dip_cnt_d = dip_cnt_q + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // reset sequencer: flags settle in the trigger cycle, reset held for a fixed pulse
  typedef enum logic [1:0] {ST_POR, ST_RUN, ST_HOLD} seq_state_e;
  seq_state_e st_q, st_d;
  logic [3:0] hold_q, hold_d;
  logic       full_q, full_d;
  logic       pcsp_q, pcsp_d;
  logic       por_q, por_d;

  // priority: flash key, then brown-out, then watchdog
  always_comb begin
    st_d   = st_q;
    hold_d = hold_q;
    full_d = full_q;
    pcsp_d = 1'b0;
    por_d  = 1'b0;
    to_d   = to_q;
    pd_d   = pd_q;
    case (st_q)
      ST_POR: begin
        to_d   = 1'b0;
        pd_d   = 1'b0;
        por_d  = 1'b1;
        full_d = 1'b0; // por_d keeps reset applied one more cycle
        st_d   = ST_RUN;
      end
      ST_RUN: begin
        if (key_hit) begin
          full_d = 1'b1;
          st_d   = ST_HOLD;
          hold_d = 4'(RST_PULSE_CYC);
        end else if (bor_fire && !sleep_q) begin
          full_d = 1'b1; // flags untouched
          st_d   = ST_HOLD;
          hold_d = 4'(RST_PULSE_CYC);
        end else if (wdt_expire && !sleep_q) begin
          to_d   = 1'b1;
          full_d = 1'b1;
          st_d   = ST_HOLD;
          hold_d = 4'(RST_PULSE_CYC);
        end else if (wdt_expire && sleep_q) begin
          to_d   = 1'b1;
          pd_d   = 1'b1;
          pcsp_d = 1'b1;
        end
      end
      ST_HOLD: begin
        if (hold_q == 4'h1) begin
          full_d = 1'b0; // released on a clock edge
          st_d   = ST_RUN;
        end else begin
          hold_d = hold_q - 4'h1;
        end
      end
      default: st_d = ST_RUN;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // power-on defaults for core and peripherals, driven one cycle behind the merged reset except the watchdog clear
  logic [PORT_W-1:0] dir_d, data_d, pull_d, wake_d;
  logic              ien_d, ten_d, wclr_d;

  always_comb begin
    ien_d  = ~(full_q | por_q);
    ten_d  = ~(full_q | por_q);
    wclr_d = full_d | por_d;    // aligned with the reset so counting resumes at release
    dir_d  = (full_q | por_q) ? PORT_W'(PORT_DIR_RST)  : port_dir;
    data_d = (full_q | por_q) ? PORT_W'(PORT_DATA_RST) : port_data;
    pull_d = (full_q | por_q) ? PORT_W'(PORT_PULL_RST) : port_pull;
    wake_d = (full_q | por_q) ? PORT_W'(PORT_WAKE_RST) : port_wake;
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // all state registers; reset loads constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_sel_q    <= WIDTH_SEL_RST;
      sleep_q        <= 1'b0;
      to_q           <= 1'b0;
      pd_q           <= 1'b0;
      rdata_q        <= 32'h0000_0000;
      err_q          <= 1'b0;
      rdy_q          <= 1'b0;
      dip_cnt_q      <= 8'h00;
      st_q           <= ST_POR;
      hold_q         <= 4'h0;
      full_q         <= 1'b1;
      pcsp_q         <= 1'b1; // pc zero, stack pointer top while held
      por_q          <= 1'b1;
      sys_reset_n    <= 1'b0;
      int_enable     <= 1'b0;
      timer_enable   <= 1'b0;
      wdt_tb_clear   <= 1'b1;
      port_dir       <= PORT_W'(PORT_DIR_RST);
      port_data      <= PORT_W'(PORT_DATA_RST);
      port_pull      <= PORT_W'(PORT_PULL_RST);
      port_wake      <= PORT_W'(PORT_WAKE_RST);
    end else begin
      width_sel_q    <= width_sel_d;
      sleep_q        <= full_d ? 1'b0 : sleep_d;
      to_q           <= to_d;
      pd_q           <= pd_d;
      rdata_q        <= rdata_d;
      err_q          <= err_d;
      rdy_q          <= rdy_d;
      dip_cnt_q      <= dip_cnt_d;
      st_q           <= st_d;
      hold_q         <= hold_d;
      full_q         <= full_d;
      pcsp_q         <= pcsp_d | full_d;
      por_q          <= por_d;
      sys_reset_n    <= ~(full_d | por_d); // flags were written in the same edge or earlier
      int_enable     <= ien_d;
      timer_enable   <= ten_d;
      wdt_tb_clear   <= wclr_d;
      port_dir       <= dir_d;
      port_data      <= data_d;
      port_pull      <= pull_d;
      port_wake      <= wake_d;
    end
  end

  assign prdata         = rdata_q;
  assign pready         = rdy_q;
  assign pslverr        = err_q;
  assign pc_sp_clear    = pcsp_q;
  assign timeout_flag   = to_q;
  assign powerdown_flag = pd_q;

  //////////////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_key_write;
    st_q == ST_RUN && psel && penable && !pready && pwrite && paddr == ADDR_FLASH_CTL1 &&
    pwdata[7:0] == 8'h55;
  endsequence

  a_width_reset: assert property (@(posedge pclk) disable iff (!presetn)
    por_q |-> width_sel_q == 2'h1) else $error("width select default wrong");
  a_bor_flags: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == ST_RUN && !key_hit && bor_fire && !sleep_q |=> $stable(to_q) && $stable(pd_q))
    else $error("brown-out changed flags");
  a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && paddr == ADDR_WIDTH_SEL |-> prdata[31:2] == 30'h0)
    else $error("width select upper bits not zero");
  a_key_reset: assert property (@(posedge pclk) disable iff (!presetn)
    s_key_write |=> !sys_reset_n) else $error("key write did not reset");
  a_wdt_run: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == ST_RUN && !key_hit && !bor_fire && wdt_expire && !sleep_q
    |=> to_q && !sys_reset_n) else $error("run watchdog reset wrong");
  a_wdt_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == ST_RUN && !key_hit && wdt_expire && sleep_q
    |=> pc_sp_clear && to_q && pd_q && sys_reset_n) else $error("sleep watchdog wrong");
  a_por_flags: assert property (@(posedge pclk) disable iff (!presetn)
    por_q |-> !to_q && !pd_q) else $error("power-on flags not cleared");
  a_reset_outs: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(sys_reset_n) |=> !int_enable && !timer_enable && wdt_tb_clear && port_dir == '1)
    else $error("reset defaults missing");
  a_dip_filter: assert property (@(posedge pclk) disable iff (!presetn)
    supply_ok_s |=> dip_cnt_q == 8'h00) else $error("dip count not restarted");
  a_release_len: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(sys_reset_n) && st_q == ST_HOLD |-> !sys_reset_n [*4] ##1 sys_reset_n)
    else $error("reset pulse length wrong");

endmodule : reset_source_control

/* design/rst_src_pkg.sv */
// constants for the reset source controller: register map, reset values, timing
// assumes an apb slave port with 32-bit data and word-aligned registers
package rst_src_pkg;

  // register byte addresses
  localparam logic [11:0] ADDR_WIDTH_SEL  = 12'h000;
  localparam logic [11:0] ADDR_FLASH_CTL1 = 12'h004;
  localparam logic [11:0] ADDR_FLAGS      = 12'h008;
  localparam logic [11:0] ADDR_CONTROL    = 12'h00C;

  // field layout and reset values
  localparam logic [1:0] WIDTH_SEL_RST  = 2'h1;
  localparam logic [7:0] FLASH_KEY      = 8'h55;
  localparam int         FLAG_TO_BIT    = 0;
  localparam int         FLAG_PD_BIT    = 1;
  localparam int         CTL_SLEEP_BIT  = 0;
  localparam logic [7:0] PORT_DIR_RST   = 8'hFF;
  localparam logic [7:0] PORT_DATA_RST  = 8'hFF;
  localparam logic [7:0] PORT_PULL_RST  = 8'h00;
  localparam logic [7:0] PORT_WAKE_RST  = 8'h00;

  // dip width in sub-clock periods, one entry per select code
  localparam int DIP_CYC_0 = 8;
  localparam int DIP_CYC_1 = 32;
  localparam int DIP_CYC_2 = 64;
  localparam int DIP_CYC_3 = 128;

  // reset pulse length held on the merged reset, in system clocks
  localparam int RST_PULSE_NS  = 16;
  localparam int CLK_PERIOD_NS = 4;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SRC_NONE, SRC_FLASH, SRC_WDT_RUN, SRC_WDT_SLEEP
  } reset_cause_e;

endpackage : rst_src_pkg

/* design/sync3.sv */
// three-flop input conditioner for a pin that is asynchronous to pclk
// assumes presetn is active low, asynchronous; output changes once stages two and three agree
`timescale 1ns/10ps
module sync3 (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  input  wire logic rst_val,
  output logic      dout
);

  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       out_q;
  logic       out_d;

  // shift; the first stage feeds only the second
  always_comb begin
    sh_d  = {sh_q[1:0], din};
    out_d = (sh_q[2] == sh_q[1]) ? sh_q[2] : out_q;
  end

  // reset loads a constant picked by wiring of rst_val is not allowed, so reset is all ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q  <= 3'h7;
      out_q <= 1'b1;
    end else begin
      sh_q  <= sh_d;
      out_q <= out_d;
    end
  end

  assign dout = out_q ^ ~rst_val;

endmodule : sync3

/* test/core_model.sv */
// far-side model of the core: takes the merged reset and pc/sp clear, fires watchdog expiry
// assumes every signal lives in the pclk domain
`timescale 1ns/10ps
module core_model (
  input  wire logic       pclk,
  input  wire logic       sys_reset_n,
  input  wire logic       pc_sp_clear,
  input  wire logic       wdt_req,
  output logic            wdt_expire,
  output logic      [7:0] pc_q
);
  //////////////////////////////////////////////////////////////////////////////////////
  logic [7:0] pc_d;

  // pc steps every cycle out of reset, so a clear shows as a drop to zero
  always_comb begin
    pc_d = pc_q + 8'h01;
    if (!sys_reset_n || pc_sp_clear) begin
      pc_d = 8'h00;
    end
  end

  // expiry is a one-cycle pulse one edge after the bench asks for it
  always_ff @(posedge pclk) begin
    wdt_expire <= wdt_req;
    pc_q       <= pc_d;
  end
endmodule : core_model

/* test/tb_top.sv */
// self-checking bench for the reset source controller, one task per scenario
// assumes the controller answers apb with one wait state and the core model shares pclk
`timescale 1ns/10ps
module tb_top
  import rst_src_pkg::*;
;
  //////////////////////////////////////////////////////////////////////////////////////
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, sub_clk_en, supply_ok, wdt_req, saw_low, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, sys_reset_n, pc_sp_clear, timeout_flag, powerdown_flag;
  logic        int_enable, wdt_tb_clear, timer_enable, wdt_expire;
  logic [7:0]  port_dir, port_data, port_pull, port_wake, pc_q;
  int          err_total = 0;
  int          num_checks = 0;
  int          cyc = 0;

  // 250 MHz
  always #2 pclk = ~pclk;

  reset_source_control #(.PORT_W(8)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sub_clk_en, .supply_ok, .wdt_expire, .sys_reset_n,
    .pc_sp_clear, .timeout_flag, .powerdown_flag, .int_enable, .wdt_tb_clear, .timer_enable,
    .port_dir, .port_data, .port_pull, .port_wake);
  core_model core_u (.pclk, .sys_reset_n, .pc_sp_clear, .wdt_req, .wdt_expire, .pc_q);

  //////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard; also notes any low cycle of the merged reset
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (sys_reset_n === 1'b0) begin
      saw_low <= 1'b1;
    end
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // one transfer; starts on a fresh edge so back-to-back calls never double-drive psel
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    chk("apb_ready", 1, pready);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // low cycles of the merged reset after an event, zero if it never falls
  task automatic rst_pulse(output int lo);
    int n;
    n  = 0;
    lo = 0;
    while (sys_reset_n !== 1'b0 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    while (sys_reset_n === 1'b0 && lo < 20) begin
      @(posedge pclk);
      lo++;
    end
    repeat (4) @(posedge pclk);
  endtask : rst_pulse

  //////////////////////////////////////////////////////////////////////////////////////
  task automatic t_poweron;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("pc_sp_clear_hold", 1, pc_sp_clear);
    chk("wdt_tb_clear_hold", 1, wdt_tb_clear);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("release_still_low", 0, sys_reset_n);
    @(posedge pclk);
    chk("release_high", 1, sys_reset_n);
    chk("to_por", 0, timeout_flag);
    chk("pd_por", 0, powerdown_flag);
    chk("int_off", 0, int_enable);
    chk("wdt_tb_run", 0, wdt_tb_clear);
    chk("timer_off", 0, timer_enable);
    chk("port_dir", 32'hFF, port_dir);
    chk("port_data", 32'hFF, port_data);
    chk("port_pull", 32'h00, port_pull);
    chk("port_wake", 32'h00, port_wake);
    chk("pc_sp_done", 0, pc_sp_clear);
  endtask : t_poweron

  task automatic t_regs;
    apb(1'b0, ADDR_WIDTH_SEL, 32'h0);
    chk("width_rst", 32'h1, rd);
    chk("mapped_ok", 0, er);
    chk("int_on", 1, int_enable);
    chk("timer_on", 1, timer_enable);
    apb(1'b1, ADDR_WIDTH_SEL, 32'hFFFF_FFFE);
    apb(1'b0, ADDR_WIDTH_SEL, 32'h0);
    chk("width_upper_zero", 32'h2, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_err", 1, er);
  endtask : t_regs

  // a near-miss key must not reset; the key gives one full pulse
  task automatic t_key;
    int lo;
    apb(1'b1, ADDR_FLASH_CTL1, 32'h54);
    rst_pulse(lo);
    chk("no_key_reset", 0, lo);
    apb(1'b1, ADDR_FLASH_CTL1, 32'h55);
    rst_pulse(lo);
    chk("key_reset_len", 4, lo);
  endtask : t_key

  task automatic t_wdt_run;
    int lo;
    wdt_req <= 1'b1;
    @(posedge pclk);
    wdt_req <= 1'b0;
    rst_pulse(lo);
    chk("wdt_reset_len", 4, lo);
    chk("to_wdt_run", 1, timeout_flag);
    chk("pd_wdt_run", 0, powerdown_flag);
  endtask : t_wdt_run

  // per code, a dip one period short is ignored and a full-width dip fires
  task automatic t_brownout;
    int dips[4] = '{8, 32, 64, 128};
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 2; k++) begin
        apb(1'b1, ADDR_WIDTH_SEL, 32'(c));
        saw_low = 1'b0;
        supply_ok <= 1'b0;
        repeat (6) @(posedge pclk);
        repeat (dips[c] - 1 + k) begin
          @(posedge pclk);
          sub_clk_en <= 1'b1;
          @(posedge pclk);
          sub_clk_en <= 1'b0;
        end
        @(posedge pclk);
        supply_ok <= 1'b1;
        repeat (12) @(posedge pclk);
        chk("bor_fire", 32'(k), saw_low);
      end
    end
    chk("to_bor_kept", 1, timeout_flag);
    chk("pd_bor_kept", 0, powerdown_flag);
  endtask : t_brownout

  task automatic t_wdt_sleep;
    int n;
    apb(1'b1, ADDR_CONTROL, 32'h1);
    saw_low = 1'b0;
    wdt_req <= 1'b1;
    @(posedge pclk);
    wdt_req <= 1'b0;
    n = 0;
    while (pc_sp_clear !== 1'b1 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    chk("pc_sp_pulse", 0, pc_sp_clear);
    chk("pc_cleared", 0, pc_q);
    repeat (8) @(posedge pclk);
    chk("no_full_reset", 0, saw_low);
    chk("port_kept", 32'hFF, port_dir);
    chk("to_sleep", 1, timeout_flag);
    chk("pd_sleep", 1, powerdown_flag);
    apb(1'b1, ADDR_FLAGS, 32'h0);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk("flags_reg", 32'h3, rd);
  endtask : t_wdt_sleep

  //////////////////////////////////////////////////////////////////////////////////////
  // second power-on at the end proves set flags are cleared again
  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    sub_clk_en = 1'b0;
    supply_ok  = 1'b1;
    wdt_req    = 1'b0;
    saw_low    = 1'b0;
    t_poweron();
    t_regs();
    t_key();
    t_wdt_run();
    t_brownout();
    t_wdt_sleep();
    t_poweron();
    tally_and_finish();
  end
endmodule : tb_top
